// ==== hw/otp_pkg.sv ====
// constants for the one-time-programmable memory host controller
//
// Behaviour
// [RULE1] blank array reads all ones; programming clears bits
// [RULE2] high gate voltage with select low programs
// [RULE3] host drives whole byte on data pins
// [RULE4] pulses 20 to 100 us, only as needed
// [RULE5] verify after pulse, retry until match or limit
// [RULE6] reread whole array at nominal supply afterwards
// [RULE7] select low pulses program; high inhibits, outputs float
// [RULE8] verify drives stored byte; sample after verify delay
// [RULE9] ident readout needs line nine at ident voltage
// [RULE10] line one high: line zero picks maker/part
// [RULE11] keep other address lines low during ident
// [RULE12] ident bytes have odd parity in msb
// [RULE13] line one low returns continuation code
// [RULE14] device drives data only when select and gate low
// [RULE15] gate controls only drivers; selection independent
// [RULE16] gate-to-data shorter than address/select access
// [RULE17] select high: standby, outputs float
// [RULE18] select per device, gate from system read strobe
package otp_pkg;
  localparam int unsigned CLK_HZ           = 20_000_000;
  localparam int unsigned ADDR_W           = 16;
  localparam int unsigned DATA_W           = 8;
  localparam int unsigned ADDR_NINE        = 9;
  localparam int unsigned ADDR_ONE         = 1;
  localparam int unsigned ADDR_ZERO        = 0;
  localparam int unsigned PULSE_MIN_NS     = 20_000;
  localparam int unsigned PULSE_MAX_NS     = 100_000;
  localparam int unsigned ACCESS_NS        = 90;
  localparam int unsigned GATE_NS          = 35;
  localparam int unsigned VERIFY_NS        = 1_000;
  localparam int unsigned SETUP_NS         = 2_000;
  localparam int unsigned NS_PER_S         = 1_000_000_000;
  // least times round up
  localparam int unsigned PULSE_CYC   = (PULSE_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned ACCESS_CYC  = (ACCESS_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned GATE_CYC    = (GATE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned VERIFY_CYC  = (VERIFY_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned SETUP_CYC   = (SETUP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned PULSE_LIMIT = 25;
  localparam logic [7:0]  BLANK_BYTE  = 8'hFF;
  localparam logic [15:0] ADDR_ZEROS  = 16'h0000;
  localparam logic [15:0] ADDR_LAST   = 16'hFFFF;
  localparam logic [1:0]  CMD_READ    = 2'h0;
  localparam logic [1:0]  CMD_PROG    = 2'h1;
  localparam logic [1:0]  CMD_IDENT   = 2'h2;
  localparam logic [1:0]  CMD_CHECK   = 2'h3;
endpackage : otp_pkg

// ==== hw/otp_host.sv ====
// host controller that reads, identifies and programs the one-time-programmable memory
`timescale 1ns/1ps
module otp_host #(
  parameter int unsigned PULSE_CYCLES = otp_pkg::PULSE_CYC,
  parameter int unsigned MAX_PULSES   = otp_pkg::PULSE_LIMIT,
  parameter int unsigned SETUP_CYCLES = otp_pkg::SETUP_CYC
) (
  input  wire logic                        core_clk,      // 20 MHz clock
  input  wire logic                        nrst,          // async reset, active low
  input  wire logic                        cmd_valid,     // start a command, one cycle
  input  wire logic [1:0]                  cmd_op,        // read, program, ident, array check
  input  wire logic [otp_pkg::ADDR_W-1:0]  cmd_addr,      // read or program address, or ident byte index
  input  wire logic [otp_pkg::DATA_W-1:0]  cmd_data,      // byte to program
  output logic                             busy,          // command in progress
  output logic                             done,          // command finished, one cycle
  output logic                             fail,          // mismatch after pulse limit, or non-blank byte in array check, with done
  output logic [otp_pkg::DATA_W-1:0]       rsp_data,      // byte read or identified
  output logic                             parity_ok,     // ident byte has odd parity
  output logic [otp_pkg::ADDR_W-1:0]       mem_addr,      // address pins
  output logic                             mem_sel_n,     // chip select, active low
  output logic                             mem_gate_n,    // output gate, active low
  output logic                             vpp_on,        // gate pin at programming voltage
  output logic                             ident_hv_on,   // line nine at ident voltage
  output logic                             vcc_margin,    // supply at raised program level
  input  wire logic [otp_pkg::DATA_W-1:0]  data_pins_i,   // data pins, level seen
  output logic [otp_pkg::DATA_W-1:0]       data_pins_o,   // data pins, value driven
  output logic                             data_pins_oe   // data pins driven by host
);
  import otp_pkg::*;

  initial begin
    if (PULSE_CYCLES < PULSE_CYC || PULSE_CYCLES > (PULSE_MAX_NS * (CLK_HZ / 1_000_000)) / 1000)
      $error("pulse length outside allowed range");
    if (MAX_PULSES < 1 || MAX_PULSES > 255 || SETUP_CYCLES < 1)
      $error("bad pulse limit or setup time");
  end

  typedef enum logic [2:0] {
    OTP_IDLE   = 3'b000,
    OTP_SETUP  = 3'b001,
    OTP_PULSE  = 3'b010,
    OTP_GAP    = 3'b011,
    OTP_VERIFY = 3'b100,
    OTP_ACCESS = 3'b101,
    OTP_FINISH = 3'b110
  } otp_state_e;

  otp_state_e                 state_q;
  logic [1:0]                 op_q;
  logic [DATA_W-1:0]          want_q;
  logic [DATA_W-1:0]          sync1_q;
  logic [DATA_W-1:0]          sync2_q;
  logic [19:0]                cnt_q;
  logic [7:0]                 pulses_q;
  logic                       bad_q;

  // -------------------------------------------------------------
  // pin input synchroniser
  // -------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sync1_q <= BLANK_BYTE;
      sync2_q <= BLANK_BYTE;
    end else begin
      sync1_q <= data_pins_i;
      sync2_q <= sync1_q;
    end
  end

  // -------------------------------------------------------------
  // sequencer
  // -------------------------------------------------------------
  // sample after access or verify delay plus two synchroniser stages
  localparam logic [19:0] READ_WAIT   = 20'(ACCESS_CYC + 2);
  localparam logic [19:0] VERIFY_WAIT = 20'(VERIFY_CYC + 2);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_q      <= OTP_IDLE;
      op_q         <= CMD_READ;
      want_q       <= BLANK_BYTE;
      cnt_q        <= 20'h00000;
      pulses_q     <= 8'h00;
      bad_q        <= 1'b0;
      busy         <= 1'b0;
      done         <= 1'b0;
      fail         <= 1'b0;
      rsp_data     <= BLANK_BYTE;
      parity_ok    <= 1'b0;
      mem_addr     <= ADDR_ZEROS;
      mem_sel_n    <= 1'b1;
      mem_gate_n   <= 1'b1;
      vpp_on       <= 1'b0;
      ident_hv_on  <= 1'b0;
      vcc_margin   <= 1'b0;
      data_pins_o  <= BLANK_BYTE;
      data_pins_oe <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (state_q)
        OTP_IDLE: begin
          if (cmd_valid) begin
            op_q     <= cmd_op;
            want_q   <= cmd_data;
            pulses_q <= 8'h00;
            bad_q    <= 1'b0;
            busy     <= 1'b1;
            fail     <= 1'b0;
            cnt_q    <= 20'h00000;
            unique case (cmd_op)
              CMD_PROG: begin
                mem_addr     <= cmd_addr;
                data_pins_o  <= cmd_data;   // [RULE3]
                data_pins_oe <= 1'b1;       // [RULE3]
                vcc_margin   <= 1'b1;
                vpp_on       <= 1'b1;       // [RULE2]
                state_q      <= OTP_SETUP;
              end
              CMD_IDENT: begin
                // only lines one and zero may be high besides nine
                mem_addr    <= {14'h0000, cmd_addr[ADDR_ONE], cmd_addr[ADDR_ZERO]}; // [RULE11]
                ident_hv_on <= 1'b1;        // [RULE9]
                state_q     <= OTP_SETUP;
              end
              CMD_CHECK: begin
                mem_addr <= ADDR_ZEROS;     // [RULE6]
                state_q  <= OTP_SETUP;
              end
              default: begin
                mem_addr <= cmd_addr;
                state_q  <= OTP_SETUP;
              end
            endcase
          end
        end
        OTP_SETUP: begin
          // let voltages and address settle before selecting
          if (cnt_q >= 20'(SETUP_CYCLES - 1)) begin
            cnt_q <= 20'h00000;
            if (op_q == CMD_PROG) begin
              mem_sel_n <= 1'b0;            // [RULE7]
              state_q   <= OTP_PULSE;
            end else begin
              mem_sel_n  <= 1'b0;           // [RULE18]
              mem_gate_n <= 1'b0;           // [RULE14]
              state_q    <= OTP_ACCESS;
            end
          end else begin
            cnt_q <= cnt_q + 20'h00001;
          end
        end
        OTP_PULSE: begin
          if (cnt_q >= 20'(PULSE_CYCLES - 1)) begin // [RULE4]
            mem_sel_n <= 1'b1;
            cnt_q     <= 20'h00000;
            pulses_q  <= pulses_q + 8'h01;
            state_q   <= OTP_GAP;
          end else begin
            cnt_q <= cnt_q + 20'h00001;
          end
        end
        OTP_GAP: begin
          // leave programming voltage, release data pins, then verify
          if (cnt_q >= 20'(SETUP_CYCLES - 1)) begin
            cnt_q      <= 20'h00000;
            mem_sel_n  <= 1'b0;             // [RULE8]
            mem_gate_n <= 1'b0;             // [RULE8]
            state_q    <= OTP_VERIFY;
          end else begin
            if (cnt_q == 20'h00000) begin
              vpp_on       <= 1'b0;
              data_pins_oe <= 1'b0;
            end
            cnt_q <= cnt_q + 20'h00001;
          end
        end
        OTP_VERIFY: begin
          if (cnt_q >= VERIFY_WAIT) begin   // [RULE8]
            cnt_q      <= 20'h00000;
            mem_sel_n  <= 1'b1;
            mem_gate_n <= 1'b1;
            rsp_data   <= sync2_q;
            if (sync2_q == want_q) begin    // [RULE5]
              state_q <= OTP_FINISH;
            end else if (pulses_q >= 8'(MAX_PULSES)) begin // [RULE5]
              fail    <= 1'b1;
              state_q <= OTP_FINISH;
            end else begin
              // one more pulse only while the byte still differs
              vpp_on       <= 1'b1;         // [RULE4]
              data_pins_oe <= 1'b1;
              state_q      <= OTP_SETUP;
            end
          end else begin
            cnt_q <= cnt_q + 20'h00001;
          end
        end
        OTP_ACCESS: begin
          if (cnt_q >= READ_WAIT) begin     // [RULE16]
            cnt_q    <= 20'h00000;
            rsp_data <= sync2_q;
            // odd parity across all eight bits
            parity_ok <= ^sync2_q;          // [RULE12]
            if (op_q == CMD_CHECK) begin
              // blank array check: any cleared bit is reported
              if (sync2_q != BLANK_BYTE)
                bad_q <= 1'b1;              // [RULE1]
              if (mem_addr == ADDR_LAST) begin
                mem_sel_n  <= 1'b1;
                mem_gate_n <= 1'b1;
                fail       <= bad_q | (sync2_q != BLANK_BYTE);
                state_q    <= OTP_FINISH;
              end else begin
                // keep select low, step address for next access
                mem_addr <= mem_addr + 16'h0001; // [RULE6]
              end
            end else begin
              mem_sel_n  <= 1'b1;           // [RULE17]
              mem_gate_n <= 1'b1;           // [RULE15]
              state_q    <= OTP_FINISH;
            end
          end else begin
            cnt_q <= cnt_q + 20'h00001;
          end
        end
        OTP_FINISH: begin
          ident_hv_on <= 1'b0;
          vcc_margin  <= 1'b0;
          vpp_on      <= 1'b0;
          data_pins_oe <= 1'b0;
          busy        <= 1'b0;
          done        <= 1'b1;
          state_q     <= OTP_IDLE;
        end
        default: state_q <= OTP_IDLE;
      endcase
    end
  end
endmodule : otp_host

// ==== sim/otp_dev_model.sv ====
// behavioural model of the one-time-programmable memory
`timescale 1ns/1ps
module otp_dev_model #(
  parameter logic [7:0] MAKER_CODE = 8'h0B, // arbitrary value, odd parity
  parameter logic [7:0] PART_CODE  = 8'hC1, // arbitrary value, odd parity
  parameter logic [7:0] CONT_CODE  = 8'h4F  // arbitrary value
) (
  input  wire logic        core_clk,    // only paces the floating pattern
  input  wire logic [15:0] mem_addr,    // address pins
  input  wire logic        mem_sel_n,   // chip select
  input  wire logic        mem_gate_n,  // output gate
  input  wire logic        vpp_on,      // gate pin at programming level
  input  wire logic        ident_hv_on, // line nine at ident level
  input  wire logic [7:0]  bus,         // data pin level
  input  wire logic [3:0]  need,        // pulses before a byte takes
  output logic      [7:0]  dq           // value the device puts out
);
  logic [7:0]  mem [0:65535];
  logic [7:0]  float_q = 8'hA5;
  logic [15:0] last_a  = 16'h0000;
  logic        armed   = 1'b0;
  int          hits    = 0;
  initial foreach (mem[i]) mem[i] = 8'hFF;
  // released pins show a changing pattern, never the last byte
  always @(posedge core_clk) float_q <= ~float_q ^ 8'h3C;
  // only a select pulse that began under programming voltage programs
  always @(negedge mem_sel_n) armed = vpp_on;
  always @(posedge mem_sel_n) if (armed && vpp_on) begin
    hits = (mem_addr == last_a) ? hits + 1 : 1;
    last_a = mem_addr;
    if (hits >= int'(need)) mem[mem_addr] = mem[mem_addr] & bus;
  end
  always @* begin
    if (!mem_sel_n && !mem_gate_n && !vpp_on) begin
      if (!ident_hv_on) dq = mem[mem_addr];
      else if (mem_addr[1]) dq = mem_addr[0] ? PART_CODE : MAKER_CODE;
      else dq = CONT_CODE;
    end else dq = float_q;
  end
endmodule : otp_dev_model

// ==== sim/otp_host_checker.sv ====
// port assertions for the memory host controller
`timescale 1ns/1ps
module otp_host_checker #(
  parameter int unsigned PULSE_CYCLES = 400
) (
  input wire logic        core_clk,     // clock
  input wire logic        nrst,         // reset
  input wire logic        done,         // completion
  input wire logic [15:0] mem_addr,     // address pins
  input wire logic        mem_sel_n,    // chip select
  input wire logic        mem_gate_n,   // output gate
  input wire logic        vpp_on,       // programming level
  input wire logic        ident_hv_on,  // ident level
  input wire logic        vcc_margin,   // raised supply
  input wire logic        data_pins_oe  // host drives data
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  logic [11:0] plen_q;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) plen_q <= 12'h000;
    else if (!mem_sel_n && vpp_on) plen_q <= plen_q + 12'h001;
    else plen_q <= 12'h000;
  end
  property p_oe_vpp; data_pins_oe |-> vpp_on; endproperty
  a_oe_vpp: assert property (p_oe_vpp) else $error("data driven outside program");
  property p_pulse_byte; vpp_on && !mem_sel_n |-> data_pins_oe; endproperty
  a_pulse_byte: assert property (p_pulse_byte) else $error("pulse without byte");
  // a select rise that ends a pulse, not one that starts a retry
  property p_pulse_len;
    $past(vpp_on) && $rose(mem_sel_n) |-> plen_q == PULSE_CYCLES;
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("pulse length wrong");
  property p_verify_after;
    $past(vpp_on) && $rose(mem_sel_n) |-> ##[1:60] (!vpp_on && !mem_sel_n && !mem_gate_n);
  endproperty
  a_verify_after: assert property (p_verify_after) else $error("no verify after pulse");
  property p_read_hold; $fell(mem_sel_n) && !vpp_on |-> !mem_sel_n [*5]; endproperty
  a_read_hold: assert property (p_read_hold) else $error("select released early");
  property p_ident_gate; ident_hv_on && !mem_sel_n |-> !mem_gate_n && !vpp_on; endproperty
  a_ident_gate: assert property (p_ident_gate) else $error("ident without gate");
  property p_ident_addr; ident_hv_on |-> mem_addr[15:2] == 14'h0000; endproperty
  a_ident_addr: assert property (p_ident_addr) else $error("ident address high");
  property p_strobe_read; !mem_gate_n && !vpp_on |-> !data_pins_oe; endproperty
  a_strobe_read: assert property (p_strobe_read) else $error("bus contention");
  property p_prog_margin; vpp_on |-> vcc_margin; endproperty
  a_prog_margin: assert property (p_prog_margin) else $error("pulse at nominal supply");
  c_pulse: cover property (vpp_on && $rose(mem_sel_n));
  c_ident: cover property (ident_hv_on && !mem_sel_n);
  c_done: cover property (done);
endmodule : otp_host_checker
bind otp_host otp_host_checker #(.PULSE_CYCLES(PULSE_CYCLES)) otp_host_checker_i (
  .core_clk(core_clk), .nrst(nrst), .done(done), .mem_addr(mem_addr), .mem_sel_n(mem_sel_n),
  .mem_gate_n(mem_gate_n), .vpp_on(vpp_on), .ident_hv_on(ident_hv_on),
  .vcc_margin(vcc_margin), .data_pins_oe(data_pins_oe));

// ==== sim/test_otp_host.sv ====
// self-checking bench for the memory host controller
`timescale 1ns/1ps
module test_otp_host;
  import otp_pkg::*;
  localparam int unsigned TRIES = 3;
  localparam logic [7:0]  MAKER = 8'h0B; // arbitrary value
  localparam logic [7:0]  PART  = 8'hC1; // arbitrary value
  localparam logic [7:0]  CONT  = 8'h4F; // arbitrary value
  logic        core_clk = 1'b0, nrst = 1'b0, cmd_valid = 1'b0;
  logic [1:0]  cmd_op   = CMD_READ;
  logic [15:0] cmd_addr = 16'h0000, mem_addr, a;
  logic [7:0]  cmd_data = 8'h00, rsp_data, data_pins_o, dq, d;
  logic        busy, done, fail, parity_ok, mem_sel_n, mem_gate_n, vpp_on, ident_hv_on;
  logic        vcc_margin, data_pins_oe;
  logic [3:0]  need = 4'h1;
  wire  [7:0]  bus = data_pins_oe ? data_pins_o : dq;
  int          errors = 0, n_compared = 0;
  otp_host #(.PULSE_CYCLES(400), .MAX_PULSES(TRIES), .SETUP_CYCLES(2)) otp_host_i (
    .core_clk(core_clk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data), .busy(busy), .done(done), .fail(fail),
    .rsp_data(rsp_data), .parity_ok(parity_ok), .mem_addr(mem_addr), .mem_sel_n(mem_sel_n),
    .mem_gate_n(mem_gate_n), .vpp_on(vpp_on), .ident_hv_on(ident_hv_on),
    .vcc_margin(vcc_margin), .data_pins_i(bus), .data_pins_o(data_pins_o),
    .data_pins_oe(data_pins_oe));
  otp_dev_model #(.MAKER_CODE(MAKER), .PART_CODE(PART), .CONT_CODE(CONT)) otp_dev_model_i (
    .core_clk(core_clk), .mem_addr(mem_addr), .mem_sel_n(mem_sel_n), .mem_gate_n(mem_gate_n),
    .vpp_on(vpp_on), .ident_hv_on(ident_hv_on), .bus(bus), .need(need), .dq(dq));
  // ----------------------------------------
  // tasks and expectations
  // ----------------------------------------
  task automatic wrap_up();
    if (errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  task automatic cmp8(input logic [7:0] got, input logic [7:0] want);
    n_compared++;
    if (got !== want) begin
      errors++;
      $display("[ERR] %0t byte %h want %h", $time, got, want);
    end
  endtask : cmp8
  task automatic cmp1(input logic got, input logic want);
    n_compared++;
    if (got !== want) begin
      errors++;
      $display("[ERR] %0t flag %b want %b", $time, got, want);
    end
  endtask : cmp1
  task automatic run(input logic [1:0] op, input logic [15:0] ad, input logic [7:0] dt);
    int n;
    cmd_op = op;
    cmd_addr = ad;
    cmd_data = dt;
    cmd_valid = 1'b1;
    @(posedge core_clk);
    #1 cmd_valid = 1'b0;
    for (n = 0; n < 5000 && done !== 1'b1; n++) begin
      @(posedge core_clk);
      #1;
    end
    if (done !== 1'b1) begin
      errors++;
      $display("[ERR] %0t no completion", $time);
    end
  endtask : run
  function automatic logic [7:0] ident_exp(input logic [1:0] i);
    return i[1] ? (i[0] ? PART : MAKER) : CONT;
  endfunction : ident_exp
  initial forever #25 core_clk = ~core_clk;
  initial begin
    repeat (40000) @(posedge core_clk);
    errors++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'h84BB9176));
    repeat (16) @(posedge core_clk);
    #1 nrst = 1'b1;
    for (int i = 0; i < 4; i++) begin
      run(CMD_IDENT, 16'(i), 8'h00);
      cmp8(rsp_data, ident_exp(2'(i)));
      cmp1(parity_ok, 1'b1);
      cmp1(busy, 1'b0);
    end
    a = 16'($urandom);
    run(CMD_READ, a, 8'h00);
    cmp8(rsp_data, 8'hFF);
    cmp1(parity_ok, 1'b0);
    for (int k = 0; k < 4; k++) begin
      a = 16'($urandom);
      d = 8'($urandom) & 8'h7E;
      need = 4'(1 + $urandom_range(2));
      run(CMD_PROG, a, d);
      cmp1(fail, 1'b0);
      run(CMD_READ, a, 8'h00);
      cmp8(rsp_data, d);
    end
    // a cleared bit cannot be set again, so verify never matches
    run(CMD_PROG, a, 8'hFF);
    cmp1(fail, 1'b1);
    run(CMD_READ, a, 8'h00);
    cmp8(rsp_data, d);
    need = 4'(TRIES + 1);
    a = a ^ 16'h8000;
    run(CMD_PROG, a, 8'h00);
    cmp1(fail, 1'b1);
    run(CMD_READ, a, 8'h00);
    cmp8(rsp_data, 8'hFF);
    // whole-array check, cut short by a reset in mid-run
    cmd_op = CMD_CHECK;
    cmd_valid = 1'b1;
    @(posedge core_clk);
    #1 cmd_valid = 1'b0;
    repeat (200) @(posedge core_clk);
    #1;
    cmp1(busy, 1'b1);
    cmp1(vcc_margin, 1'b0);
    cmp1(mem_addr != 16'h0000, 1'b1);
    cmp1(mem_sel_n, 1'b0);
    nrst = 1'b0;
    repeat (2) @(posedge core_clk);
    #1 nrst = 1'b1;
    cmp1(mem_sel_n, 1'b1);
    cmp1(busy, 1'b0);
    run(CMD_READ, a, 8'h00);
    cmp8(rsp_data, 8'hFF);
    wrap_up();
  end
endmodule : test_otp_host
